// ---- verilog/hbp_pkg.sv ----
// Constants shared by both ends of the parallel host register port.
// Assumes both ends run on one clk; offsets are the byte offsets
// that the four direct address lines select.
package hbp_pkg;
	// Direct register offsets, Address[5:0]
	localparam logic [5:0] OFS_Q0 = 6'h00;
	localparam logic [5:0] OFS_Q1 = 6'h04;
	localparam logic [5:0] OFS_Q2 = 6'h08;
	localparam logic [5:0] OFS_Q3 = 6'h0c;
	localparam logic [5:0] OFS_RSV0 = 6'h10;
	localparam logic [5:0] OFS_RSV1 = 6'h14;
	localparam logic [5:0] OFS_HQ0 = 6'h18;
	localparam logic [5:0] OFS_HQ1 = 6'h1c;
	localparam logic [5:0] OFS_QSTAT = 6'h20;
	localparam logic [5:0] OFS_TSTAT = 6'h24;
	localparam logic [5:0] OFS_USTAT = 6'h28;
	localparam logic [5:0] OFS_CSTAT = 6'h2c;
	localparam logic [5:0] OFS_IADDR = 6'h30;
	localparam logic [5:0] OFS_IDATA = 6'h34;
	localparam logic [5:0] OFS_TXD0 = 6'h38;
	localparam logic [5:0] OFS_TXD1 = 6'h3c;
	// Reset values
	localparam logic [15:0] QSTAT_RST = 16'h0f00;
	localparam logic [15:0] STAT_RST = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// Controller registers on the AHB-Lite side
	localparam logic [7:0] H_CTRL = 8'h00;
	localparam logic [7:0] H_WDATA = 8'h04;
	localparam logic [7:0] H_RDATA = 8'h08;
	localparam logic [7:0] H_STAT = 8'h0c;
	localparam logic [7:0] H_ISTAT = 8'h10;
	localparam logic [7:0] H_IMASK = 8'h14;
	// Control field positions
	localparam int CTRL_WR_BIT = 4;
	localparam int CTRL_MUX_BIT = 5;
	localparam int CTRL_GO_BIT = 8;
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_ALE = 3'h1,
		HS_STRB = 3'h3,
		HS_HOLD = 3'h2,
		HS_END = 3'h6
	} hbp_hstate_t;
endpackage

// ---- verilog/hbp_if.sv ----
// Pins between the host processor bus and the switch host port.
// Assumes one clock for both ends; the shared data lines are
// resolved here from the two output enables (active low).
`timescale 1ns/1ps
interface hbp_if;
	logic [3:0] addr;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic ale;
	logic [31:0] h_dout;
	logic h_doe_n;
	logic [31:0] d_dout;
	logic d_doe_n;
	logic [31:0] dbus;
	logic [2:0] irq;
	assign dbus = !h_doe_n ? h_dout : (!d_doe_n ? d_dout : 32'h0000_0000);
	modport host (output addr, output cs_n, output rd_n, output wr_n,
		output ale, output h_dout, output h_doe_n, input dbus,
		input irq);
	modport dev (input addr, input cs_n, input rd_n, input wr_n,
		input ale, output d_dout, output d_doe_n, input dbus,
		output irq);
endinterface

// ---- verilog/hbp_sticky.sv ----
// Sticky event bits with write-one-to-clear.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module hbp_sticky #(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] bits;
	} hbp_stk_t;
	hbp_stk_t s_q;
	hbp_stk_t s_d;
	always_comb begin
		// Set wins over a clear in the same cycle
		s_d.bits = (s_q.bits & ~clr) | set;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q.bits <= RST;
		end else begin
			s_q <= s_d;
		end
	end
	assign q = s_q.bits;
endmodule // hbp_sticky

// ---- verilog/hbp_dev.sv ----
// Device end of the parallel host register port: 16 direct registers,
// queue ports, event status, indirect window and three interrupt lines.
// Assumes the host strobes run on clk; straps are steady during srst.
//
// Overview of operation
// - Four address bits, 16 or 32 data lines
// - Registers word aligned, host drives A5..A2
// - Lowest address line same for both widths
// - Indirect data only on lower 16 lines
// - Host splits wide registers into repeated accesses; here each 16-bit queue access carries bits 15:0 only and pops or pushes
// - Strap low: separate address and data lines
// - Strap high: address and data share lines
// - Sixteen direct registers, one cycle each
// - Indirect pointer then indirect data window
// - Frames move through four queue data ports
// - Shared offsets decoded by access direction
// - Three interrupt lines with four status registers
// - Little-endian 16-bit swaps bytes, upper zero
// - Interrupt high until all its sources clear
`timescale 1ns/1ps
module hbp_dev #(
	parameter int DW = 32,
	parameter int SW = 16
) (
	input wire logic clk,
	input wire logic srst,
	hbp_if.dev bus,
	input wire logic bus_mux_select,
	input wire logic bus_wide,
	input wire logic little_endian,
	input wire logic [3:0][DW-1:0] rxq_data,
	output logic [3:0] rxq_pop,
	output logic [3:0] txq_push,
	input wire logic [1:0][DW-1:0] hq_data,
	output logic [1:0] hq_pop,
	output logic [1:0] hq_head_wr,
	output logic [DW-1:0] wr_data,
	input wire logic [1:0][SW-1:0] tx_done_cnt,
	output logic [SW-1:0] ind_addr,
	output logic ind_rd,
	output logic ind_wr,
	input wire logic [SW-1:0] ind_rdata,
	input wire logic [SW-1:0] q_event,
	input wire logic [SW-1:0] t_event,
	input wire logic [SW-1:0] u_event
);
	typedef struct packed {
		logic mux;
		logic wide;
		logic le;
		logic [3:0] adr;
		logic served;
		logic drive;
		logic [DW-1:0] rdata;
		logic [SW-1:0] iaddr;
		logic [DW-1:0] wdata;
		logic [3:0] rxq_pop;
		logic [3:0] txq_push;
		logic [1:0] hq_pop;
		logic [1:0] hq_head;
		logic ind_rd;
		logic ind_wr;
		logic [2:0] irq;
	} hbp_dev_t;

	hbp_dev_t s_q;
	hbp_dev_t s_d;
	logic [SW-1:0] qstat;
	logic [SW-1:0] tstat;
	logic [SW-1:0] ustat;
	logic [SW-1:0] qclr;
	logic [SW-1:0] tclr;
	logic [SW-1:0] uclr;

	// Byte lanes on the pins; the same map serves both directions
	function automatic logic [DW-1:0] lanes(input logic [DW-1:0] v,
		input logic narrow, input logic le);
		logic [DW-1:0] r;
		r = v;
		if (narrow) begin
			r = {16'h0000, le ? {v[7:0], v[15:8]} : v[15:0]};
		end else if (le) begin
			r = {v[7:0], v[15:8], v[23:16], v[31:24]};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	hbp_sticky #(.W(SW), .RST(hbp_pkg::QSTAT_RST)) u_qstat (
		.clk(clk),
		.srst(srst),
		.set(q_event),
		.clr(qclr),
		.q(qstat)
	);
	hbp_sticky #(.W(SW), .RST(hbp_pkg::STAT_RST)) u_tstat (
		.clk(clk),
		.srst(srst),
		.set(t_event),
		.clr(tclr),
		.q(tstat)
	);
	hbp_sticky #(.W(SW), .RST(hbp_pkg::STAT_RST)) u_ustat (
		.clk(clk),
		.srst(srst),
		.set(u_event),
		.clr(uclr),
		.q(ustat)
	);

	////////////////////////////////////////////////////////////////////
	logic rd_act;
	logic wr_act;
	logic [5:0] ofs;
	logic reg16;
	logic [DW-1:0] win;
	logic [DW-1:0] rv;

	always_comb begin
		s_d = s_q;
		s_d.rxq_pop = 4'h0;
		s_d.txq_push = 4'h0;
		s_d.hq_pop = 2'h0;
		s_d.hq_head = 2'h0;
		s_d.ind_rd = 1'b0;
		s_d.ind_wr = 1'b0;
		qclr = '0;
		tclr = '0;
		uclr = '0;
		rv = '0;
		rd_act = !bus.cs_n && !bus.rd_n;
		wr_act = !bus.cs_n && !bus.wr_n;
		// Multiplexed mode latches the address off the data lines
		if (s_q.mux && !bus.cs_n && bus.ale) begin
			s_d.adr = bus.dbus[5:2];
		end
		// Same A5..A2 sampling for both widths
		ofs = {s_q.mux ? s_q.adr : bus.addr, 2'b00};
		reg16 = ofs[5];
		win = lanes(bus.dbus, !s_q.wide || reg16, s_q.le);
		// One action per strobe, however long it is held
		s_d.served = rd_act || wr_act;
		s_d.drive = rd_act;
		if (wr_act && !s_q.served) begin
			s_d.wdata = win;
			case (ofs)
			hbp_pkg::OFS_Q0, hbp_pkg::OFS_Q1,
			hbp_pkg::OFS_Q2, hbp_pkg::OFS_Q3: begin
				s_d.txq_push[ofs[3:2]] = 1'b1;
			end
			hbp_pkg::OFS_HQ0: s_d.hq_head[0] = 1'b1;
			hbp_pkg::OFS_HQ1: s_d.hq_head[1] = 1'b1;
			hbp_pkg::OFS_QSTAT: qclr = win[SW-1:0];
			hbp_pkg::OFS_TSTAT: tclr = win[SW-1:0];
			hbp_pkg::OFS_USTAT: uclr = win[SW-1:0];
			hbp_pkg::OFS_IADDR: s_d.iaddr = win[SW-1:0];
			hbp_pkg::OFS_IDATA: s_d.ind_wr = 1'b1;
			default: begin
			end
			endcase
		end
		if (rd_act && !s_q.served) begin
			case (ofs)
			hbp_pkg::OFS_Q0, hbp_pkg::OFS_Q1,
			hbp_pkg::OFS_Q2, hbp_pkg::OFS_Q3: begin
				rv = rxq_data[ofs[3:2]];
				s_d.rxq_pop[ofs[3:2]] = 1'b1;
			end
			hbp_pkg::OFS_HQ0: begin
				rv = hq_data[0];
				s_d.hq_pop[0] = 1'b1;
			end
			hbp_pkg::OFS_HQ1: begin
				rv = hq_data[1];
				s_d.hq_pop[1] = 1'b1;
			end
			hbp_pkg::OFS_QSTAT: rv = {16'h0000, qstat};
			hbp_pkg::OFS_TSTAT: rv = {16'h0000, tstat};
			hbp_pkg::OFS_USTAT: rv = {16'h0000, ustat};
			hbp_pkg::OFS_CSTAT: rv = {29'h0, s_q.irq};
			hbp_pkg::OFS_IADDR: rv = {16'h0000, s_q.iaddr};
			hbp_pkg::OFS_IDATA: begin
				rv = {16'h0000, ind_rdata};
				s_d.ind_rd = 1'b1;
			end
			hbp_pkg::OFS_TXD0: rv = {16'h0000, tx_done_cnt[0]};
			hbp_pkg::OFS_TXD1: rv = {16'h0000, tx_done_cnt[1]};
			default: rv = '0;
			endcase
			s_d.rdata = lanes(rv, !s_q.wide || reg16, s_q.le);
		end
		// Line stays high while any mapped source is pending
		s_d.irq = {|ustat, |tstat, |qstat};
	end

	////////////////////////////////////////////////////////////////////
	// Straps are caught while reset is held and kept until next reset
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.mux <= bus_mux_select;
			s_q.wide <= bus_wide;
			s_q.le <= little_endian;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.d_dout = s_q.rdata;
	assign bus.d_doe_n = !s_q.drive;
	assign bus.irq = s_q.irq;
	assign rxq_pop = s_q.rxq_pop;
	assign txq_push = s_q.txq_push;
	assign hq_pop = s_q.hq_pop;
	assign hq_head_wr = s_q.hq_head;
	assign wr_data = s_q.wdata;
	assign ind_addr = s_q.iaddr;
	assign ind_rd = s_q.ind_rd;
	assign ind_wr = s_q.ind_wr;
endmodule // hbp_dev

// ---- verilog/hbp_host.sv ----
// Host end: an AHB-Lite slave register set that drives one host bus
// cycle per command on the parallel port and reports the result.
// Assumes AHB-Lite single word transfers on clk; bytes on the pins are
// raw, software applies the lane order it configured on the device.
`timescale 1ns/1ps
module hbp_host (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	hbp_if.host bus
);
	typedef struct packed {
		hbp_pkg::hbp_hstate_t st;
		logic a_wr;
		logic [7:0] a_ofs;
		logic [31:0] hrdata;
		logic [9:0] ctrl;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [3:0] istat;
		logic [3:0] imask;
		logic [2:0] irq_prev;
		logic [3:0] addr;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic [31:0] dout;
		logic doe_n;
		logic irq;
	} hbp_host_t;

	hbp_host_t s_q;
	hbp_host_t s_d;
	logic aphase;
	logic [3:0] ev;

	always_comb begin
		s_d = s_q;
		ev = 4'h0;
		aphase = hsel && hready && htrans[1];
		// Data phase of a write
		if (s_q.a_wr) begin
			case (s_q.a_ofs)
			hbp_pkg::H_CTRL: begin
				// A pending go counts as busy, so it is not overwritten
				if (s_q.st == hbp_pkg::HS_IDLE &&
					!s_q.ctrl[hbp_pkg::CTRL_GO_BIT]) begin
					s_d.ctrl = hwdata[9:0];
				end
			end
			hbp_pkg::H_WDATA: s_d.wdata = hwdata;
			hbp_pkg::H_ISTAT: s_d.istat = s_q.istat & ~hwdata[3:0];
			hbp_pkg::H_IMASK: s_d.imask = hwdata[3:0];
			default: begin
			end
			endcase
		end
		s_d.a_wr = aphase && hwrite;
		s_d.a_ofs = {haddr[7:2], 2'b00};
		if (aphase && !hwrite) begin
			case ({haddr[7:2], 2'b00})
			hbp_pkg::H_CTRL: s_d.hrdata = {22'h0, s_q.ctrl};
			hbp_pkg::H_WDATA: s_d.hrdata = s_q.wdata;
			hbp_pkg::H_RDATA: s_d.hrdata = s_q.rdata;
			hbp_pkg::H_STAT: s_d.hrdata = {28'h0, bus.irq,
				s_q.st != hbp_pkg::HS_IDLE};
			hbp_pkg::H_ISTAT: s_d.hrdata = {28'h0, s_q.istat};
			hbp_pkg::H_IMASK: s_d.hrdata = {28'h0, s_q.imask};
			default: s_d.hrdata = 32'h0000_0000;
			endcase
		end

		////////////////////////////////////////////////////////////
		case (s_q.st)
		hbp_pkg::HS_IDLE: begin
			if (s_q.ctrl[hbp_pkg::CTRL_GO_BIT]) begin
				s_d.ctrl[hbp_pkg::CTRL_GO_BIT] = 1'b0;
				s_d.cs_n = 1'b0;
				s_d.addr = s_q.ctrl[3:0];
				if (s_q.ctrl[hbp_pkg::CTRL_MUX_BIT]) begin
					// Address goes out on D5..D2 with the latch strobe
					s_d.st = hbp_pkg::HS_ALE;
					s_d.ale = 1'b1;
					s_d.dout = {26'h0, s_q.ctrl[3:0], 2'b00};
					s_d.doe_n = 1'b0;
				end else begin
					s_d.st = hbp_pkg::HS_STRB;
					s_d.wr_n = !s_q.ctrl[hbp_pkg::CTRL_WR_BIT];
					s_d.rd_n = s_q.ctrl[hbp_pkg::CTRL_WR_BIT];
					s_d.dout = s_q.wdata;
					s_d.doe_n = !s_q.ctrl[hbp_pkg::CTRL_WR_BIT];
				end
			end
		end
		hbp_pkg::HS_ALE: begin
			s_d.st = hbp_pkg::HS_STRB;
			s_d.ale = 1'b0;
			s_d.wr_n = !s_q.ctrl[hbp_pkg::CTRL_WR_BIT];
			s_d.rd_n = s_q.ctrl[hbp_pkg::CTRL_WR_BIT];
			s_d.dout = s_q.wdata;
			s_d.doe_n = !s_q.ctrl[hbp_pkg::CTRL_WR_BIT];
		end
		hbp_pkg::HS_STRB: begin
			// Reads hold the strobe one more cycle for the device answer
			s_d.st = s_q.wr_n ? hbp_pkg::HS_HOLD : hbp_pkg::HS_END;
			s_d.wr_n = 1'b1;
			s_d.doe_n = 1'b1;
			s_d.cs_n = !s_q.wr_n;
		end
		hbp_pkg::HS_HOLD: begin
			s_d.st = hbp_pkg::HS_END;
			s_d.rdata = bus.dbus;
			s_d.rd_n = 1'b1;
			s_d.cs_n = 1'b1;
		end
		hbp_pkg::HS_END: begin
			// Turnaround cycle: the device may still drive the lines
			s_d.st = hbp_pkg::HS_IDLE;
			ev[0] = 1'b1;
		end
		default: s_d.st = hbp_pkg::HS_IDLE;
		endcase
		ev[3:1] = bus.irq & ~s_q.irq_prev;
		s_d.irq_prev = bus.irq;
		// New events win over a clear in the same cycle
		s_d.istat = s_d.istat | ev;
		s_d.irq = |(s_d.istat & s_d.imask);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.st <= hbp_pkg::HS_IDLE;
			s_q.cs_n <= 1'b1;
			s_q.rd_n <= 1'b1;
			s_q.wr_n <= 1'b1;
			s_q.doe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.hrdata;
	assign irq = s_q.irq;
	assign bus.addr = s_q.addr;
	assign bus.cs_n = s_q.cs_n;
	assign bus.rd_n = s_q.rd_n;
	assign bus.wr_n = s_q.wr_n;
	assign bus.ale = s_q.ale;
	assign bus.h_dout = s_q.dout;
	assign bus.h_doe_n = s_q.doe_n;
endmodule // hbp_host

// ---- tb/hbp_props.sv ----
// Checker on the pins that join the host and device ends.
// Assumes one clk and a synchronous, active high srst.
`timescale 1ns/1ps
module hbp_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] addr,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ale,
	input wire logic [31:0] h_dout,
	input wire logic h_doe_n,
	input wire logic [31:0] d_dout,
	input wire logic d_doe_n,
	input wire logic [31:0] dbus,
	input wire logic [2:0] irq
);
	logic mux_q;
	logic [3:0] la_q;
	logic [3:0] eff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Mux mode is only known from the address latch cycles seen
	always_ff @(posedge clk) begin
		mux_q <= srst ? 1'b0 : (mux_q | ale);
		if (!cs_n && ale) begin
			la_q <= dbus[5:2];
		end
	end
	assign eff = mux_q ? la_q : addr;
	property p_one_drv;
		!(!h_doe_n && !d_doe_n);
	endproperty
	a_one_drv: assert property (p_one_drv)
		else $error("both ends drive data");
	property p_rd_ans;
		!cs_n && !rd_n && !ale && $past(rd_n) |=> !d_doe_n;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read data late");
	property p_rd_rel;
		rd_n && $past(rd_n) |-> d_doe_n;
	endproperty
	a_rd_rel: assert property (p_rd_rel)
		else $error("device drives outside read");
	property p_narrow;
		!d_doe_n && !rd_n && eff[3] |-> d_dout[31:16] == 16'h0000;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("upper lines not zero");
	property p_irq_rst;
		$fell(srst) |-> irq == 3'h0 ##1 irq[0];
	endproperty
	a_irq_rst: assert property (p_irq_rst)
		else $error("queue irq after reset wrong");
	property p_wr_drv;
		!wr_n && !ale |-> !h_doe_n && !cs_n;
	endproperty
	a_wr_drv: assert property (p_wr_drv)
		else $error("write without host data");
	property p_ale;
		ale |-> !h_doe_n && !cs_n && rd_n && wr_n;
	endproperty
	a_ale: assert property (p_ale)
		else $error("bad address latch cycle");
	property p_cyc;
		$fell(cs_n) |-> ##[1:8] cs_n;
	endproperty
	a_cyc: assert property (p_cyc)
		else $error("host cycle too long");
	c_rd: cover property (!d_doe_n);
	c_wr: cover property (!wr_n);
	c_ale: cover property (ale);
	c_irq: cover property (irq[1]);
endmodule // hbp_props

// ---- tb/host_bus_register_port_tb.sv ----
// Bench: AHB-Lite master on the host end, device side ports driven.
// Assumes 50 MHz clk; big endian unless a scenario straps otherwise.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module host_bus_register_port_tb;
	logic clk, srst, hsel, hwrite, hreadyout, hresp, irq;
	logic mux, wide, le, ird, iwr;
	logic [1:0] htrans, hpop, hhw;
	logic [31:0] haddr, hwdata, hrdata, wrd, rd, hr;
	logic [3:0][31:0] rxq;
	logic [1:0][31:0] hqd;
	logic [1:0][15:0] txd;
	logic [15:0] qe, te, ue, iad;
	logic [3:0] pop, push, lp, lq;
	logic [1:0] lh, lw;
	int nrd = 0;
	int miscompares = 0;
	int checked = 0;
	int nwr = 0;
	hbp_if bus ();
	hbp_dev hbp_dev_inst (.clk(clk), .srst(srst), .bus(bus.dev),
		.bus_mux_select(mux), .bus_wide(wide), .little_endian(le),
		.rxq_data(rxq), .rxq_pop(pop), .txq_push(push), .hq_data(hqd),
		.hq_pop(hpop), .hq_head_wr(hhw), .wr_data(wrd), .tx_done_cnt(txd),
		.ind_addr(iad), .ind_rd(ird), .ind_wr(iwr), .ind_rdata(~iad),
		.q_event(qe), .t_event(te), .u_event(ue));
	hbp_host hbp_host_inst (.clk(clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq(irq), .bus(bus.host));
	hbp_props hbp_props_inst (.clk(clk), .srst(srst), .addr(bus.addr),
		.cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .ale(bus.ale),
		.h_dout(bus.h_dout), .h_doe_n(bus.h_doe_n), .d_dout(bus.d_dout),
		.d_doe_n(bus.d_doe_n), .dbus(bus.dbus), .irq(bus.irq));
	always @(posedge clk) begin
		if (|push) lp <= push;
		if (|pop) lq <= pop;
		if (iwr) nwr <= nwr + 1;
		if (|hpop) lh <= hpop;
		if (|hhw) lw <= hhw;
		if (ird) nrd <= nrd + 1;
	end
	////////////////////////////////////////////////////////////////////
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hr = hrdata;
	endtask
	// Done flag, not busy: busy may not show yet right after the go
	task automatic op(input logic w, input logic [5:0] o,
		input logic [31:0] d);
		ahb(1'b1, hbp_pkg::H_ISTAT, 32'h00000001);
		ahb(1'b1, hbp_pkg::H_WDATA, d);
		ahb(1'b1, hbp_pkg::H_CTRL, {23'h0, 1'b1, 2'h0, mux, w, o[5:2]});
		do ahb(1'b0, hbp_pkg::H_ISTAT, 32'h0); while (hr[0] !== 1'b1);
		ahb(1'b0, hbp_pkg::H_RDATA, 32'h0);
		rd = hr;
	endtask
	task automatic rdc(input string n, input logic [5:0] o,
		input logic [31:0] e);
		op(1'b0, o, 32'h0);
		`CHK(n, e, rd)
	endtask
	task automatic rst(input logic m, input logic w, input logic l);
		mux <= m;
		wide <= w;
		le <= l;
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc("qstat", hbp_pkg::OFS_QSTAT, 32'h00000f00);
		rdc("cstat", hbp_pkg::OFS_CSTAT, 32'h00000001);
		rdc("iaddr", hbp_pkg::OFS_IADDR, 32'h0);
	endtask
	task automatic t_queues;
		for (int q = 0; q < 4; q++) begin
			rxq[q] <= 32'h12340000 + q;
			rdc("rx port", 6'(q * 4), 32'h12340000 + q);
			`CHK("pop", 4'h1 << q, lq)
			op(1'b1, 6'(q * 4), 32'hc0de0000 + q);
			`CHK("push", 4'h1 << q, lp)
			`CHK("wr data", 32'hc0de0000 + q, wrd)
		end
		hqd[1] <= 32'h5a5a0001;
		rdc("hq1", hbp_pkg::OFS_HQ1, 32'h5a5a0001);
		`CHK("hq pop", 2'h2, lh)
		op(1'b1, hbp_pkg::OFS_HQ0, 32'h13570000);
		`CHK("hq head", 2'h1, lw)
		`CHK("hq wr data", 32'h13570000, wrd)
	endtask
	task automatic t_indirect;
		int n0;
		int r0;
		n0 = nwr;
		r0 = nrd;
		op(1'b1, hbp_pkg::OFS_IADDR, 32'h00001234);
		`CHK("ptr", 16'h1234, iad)
		rdc("ind rd", hbp_pkg::OFS_IDATA, 32'h0000edcb);
		`CHK("ind rd pulse", 1, nrd - r0)
		op(1'b1, hbp_pkg::OFS_IDATA, 32'hffff5a5a);
		op(1'b1, hbp_pkg::OFS_IDATA, 32'hffffa5a5);
		`CHK("ind wr", 2, nwr - n0)
		`CHK("wr low", 16'ha5a5, wrd[15:0])
		`CHK("wr high", 16'h0000, wrd[31:16])
		`CHK("no rd on wr", 1, nrd - r0)
		rdc("ptr rd", hbp_pkg::OFS_IADDR, 32'h00001234);
	endtask
	task automatic t_reserved;
		txd[1] <= 16'h0033;
		rdc("rsv0", hbp_pkg::OFS_RSV0, 32'h0);
		rdc("rsv1", hbp_pkg::OFS_RSV1, 32'h0);
		op(1'b1, hbp_pkg::OFS_TXD1, 32'hffffffff);
		rdc("txd1", hbp_pkg::OFS_TXD1, 32'h00000033);
		ahb(1'b1, 8'h40, 32'h1);
		ahb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, hr)
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic t_irq;
		op(1'b1, hbp_pkg::OFS_QSTAT, 32'h00000f00);
		`CHK("irq0 clr", 1'b0, bus.irq[0])
		ahb(1'b1, hbp_pkg::H_IMASK, 32'h4);
		te <= 16'h0021;
		ue <= 16'h0001;
		@(posedge clk);
		te <= 16'h0;
		ue <= 16'h0;
		repeat (4) @(posedge clk);
		`CHK("irq lines", 3'h6, bus.irq)
		`CHK("host irq", 1'b1, irq)
		ahb(1'b0, hbp_pkg::H_STAT, 32'h0);
		`CHK("stat", 32'h0000000c, hr)
		ahb(1'b1, hbp_pkg::H_IMASK, 32'h0);
		repeat (2) @(posedge clk);
		`CHK("masked", 1'b0, irq)
		op(1'b1, hbp_pkg::OFS_TSTAT, 32'h1);
		`CHK("irq1 held", 1'b1, bus.irq[1])
		op(1'b1, hbp_pkg::OFS_TSTAT, 32'h20);
		op(1'b1, hbp_pkg::OFS_USTAT, 32'h1);
		`CHK("irq clr", 3'h0, bus.irq)
		ahb(1'b1, hbp_pkg::H_ISTAT, 32'he);
		ahb(1'b1, hbp_pkg::H_IMASK, 32'he);
		repeat (2) @(posedge clk);
		`CHK("istat clr", 1'b0, irq)
	endtask
	task automatic t_narrow;
		rst(1'b0, 1'b0, 1'b1);
		op(1'b1, hbp_pkg::OFS_IADDR, 32'h00000f0e);
		`CHK("le ptr", 16'h0e0f, iad)
		rdc("le rd", hbp_pkg::OFS_IADDR, 32'h00000f0e);
		rxq[1] <= 32'h00000e0f;
		rdc("le q1", hbp_pkg::OFS_Q1, 32'h00000f0e);
		// Wide little endian with the shared lines: 16-bit pointer bytes swapped, queue word bytes fully reversed
		rst(1'b1, 1'b1, 1'b1);
		op(1'b1, hbp_pkg::OFS_IADDR, 32'h0000a500);
		`CHK("mux ptr", 16'h00a5, iad)
		rxq[2] <= 32'h87654321;
		rdc("mux q2", hbp_pkg::OFS_Q2, 32'h21436587);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{rxq, hqd, txd, qe, te, ue} = '0;
		rst(1'b0, 1'b1, 1'b0);
		t_reset;
		t_queues;
		t_indirect;
		t_reserved;
		t_irq;
		t_narrow;
		tally_and_finish;
	end
	initial begin
		#400000;
		miscompares++;
		tally_and_finish;
	end
endmodule // host_bus_register_port_tb
